/* File: core/sdc_regs.svh */
// register offsets, field positions and reset values of the divider config bank
`ifndef SDC_REGS_SVH
`define SDC_REGS_SVH
`define SDC_WORD_W 32
`define SDC_ADDR_DIV 3'h0
`define SDC_ADDR_FRL 3'h1
`define SDC_ADDR_REF 3'h2
`define SDC_ADDR_DEV 3'h5
`define SDC_ADDR_STEP 3'h6
`define SDC_ADDR_DLY 3'h7
`define SDC_DIV_RAMP_BIT 31
`define SDC_DIV_MUX_HI 30
`define SDC_DIV_MUX_LO 27
`define SDC_DIV_INT_HI 26
`define SDC_DIV_INT_LO 15
`define SDC_DIV_FMSB_HI 14
`define SDC_DIV_FMSB_LO 3
`define SDC_FRL_PHEN_BIT 28
`define SDC_FRL_FLSB_HI 27
`define SDC_FRL_FLSB_LO 15
`define SDC_FRL_PH_HI 14
`define SDC_FRL_PH_LO 3
`define SDC_REF_CSR_BIT 28
`define SDC_REF_CP_HI 27
`define SDC_REF_CP_LO 24
`define SDC_REF_PRE_BIT 22
`define SDC_REF_HALF_BIT 21
`define SDC_REF_DBL_BIT 20
`define SDC_REF_RCNT_HI 19
`define SDC_REF_RCNT_LO 15
`define SDC_REF_STEP_CLOCK_DIVIDER_HI 14
`define SDC_REF_STEP_CLOCK_DIVIDER_LO 3
`define SDC_RESET_WORD 32'h0000_0000
`endif

/* File: core/sdc_pkg.sv */
// types shared by the divider config bank
package sdc_pkg;
  typedef enum logic {SDC_PRE_4_5, SDC_PRE_8_9} sdc_prescale_t;
  typedef struct packed {
    logic ramp_enable;
    logic [3:0] output_mux_select;
    logic [11:0] int_value;
    logic [24:0] fractional_divide_value;
    logic phase_enable;
    logic [11:0] phase_word;
    logic phase_strobe;
    logic cycle_slip_reduce_enable;
    logic [3:0] charge_pump_current;
    sdc_prescale_t prescaler;
    logic reference_halver_enable;
    logic reference_doubler_enable;
    logic [4:0] reference_count;
    logic [11:0] step_clock_divider;
  } sdc_cfg_t;
  typedef struct packed {
    logic [31:0] deviation;
    logic [31:0] step;
    logic [31:0] delay;
  } sdc_sweep_t;
endpackage : sdc_pkg

/* File: core/sdc_shift_in.sv */
// three-wire serial word capture with pin synchronisers
`timescale 1ns/1ps
`include "sdc_regs.svh"
module sdc_shift_in
  import sdc_pkg::*;
#(
  parameter int WORD_W = `SDC_WORD_W
) (
  input wire logic clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic ser_clk, // serial clock pin
  input wire logic ser_data, // serial data pin
  input wire logic ser_load, // load enable pin
  output logic [WORD_W-1:0] word, // captured word
  output logic word_valid // one-cycle pulse on load
);
  // the destination code and field layout assume 32-bit words
  if (WORD_W != 32) begin : g_bad_word
    $error("sdc_shift_in: word must be 32 bits");
  end
  logic [2:0] s1_r, s2_r, s1_nxt, s2_nxt;
  logic ck_d_r, ld_d_r, ck_d_nxt, ld_d_nxt;
  logic [WORD_W-1:0] sh_r, sh_nxt, word_r, word_nxt;
  logic vld_r, vld_nxt;
  // sync pins, shift msb first on sck rise, latch on load rise
  always_comb begin
    s1_nxt = {ser_clk, ser_data, ser_load};
    s2_nxt = s1_r;
    ck_d_nxt = s2_r[2];
    ld_d_nxt = s2_r[0];
    sh_nxt = sh_r;
    word_nxt = word_r;
    vld_nxt = 1'b0;
    if (s2_r[2] && !ck_d_r) begin
      sh_nxt = {sh_r[WORD_W-2:0], s2_r[1]};
    end
    if (s2_r[0] && !ld_d_r) begin
      word_nxt = sh_r;
      vld_nxt = 1'b1;
    end
  end
  // register stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= 3'h0;
      s2_r <= 3'h0;
      ck_d_r <= 1'b0;
      ld_d_r <= 1'b0;
      sh_r <= '0;
      word_r <= '0;
      vld_r <= 1'b0;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      ck_d_r <= ck_d_nxt;
      ld_d_r <= ld_d_nxt;
      sh_r <= sh_nxt;
      word_r <= word_nxt;
      vld_r <= vld_nxt;
    end
  end
  assign word = word_r;
  assign word_valid = vld_r;
endmodule : sdc_shift_in

/* File: core/sdc_config_bank.sv */
// write-only configuration register bank of the fractional-n synthesizer
//
// What this block does, and what the host must do
// R1 - low three bits route word: 000 divider, 001 fraction low, 010 reference
// R2 - divider bit 31 enables the frequency ramp
// R3 - divider bits 30:27 select the multiplexed output source
// R4 - divider bits 26:15 hold the twelve-bit integer divide value
// R5 - fraction is divider 14:3 above fraction-low 27:15, 25 bits
// R6 - fraction-low bit 28 enables phase adjustment
// R7 - phase word 14:3 advances phase, applied at next divider write
// R8 - host sets phase word zero when phase adjust unused
// R9 - host writes zero into reserved bits
// R10 - reference bit 28 enables cycle slip reduction
// R11 - host enables slip reduction only with proper polarity, current, duty
// R12 - reference bits 27:24 select charge pump current
// R13 - host limits pump current to 0..7 with doubler on
// R14 - reference bit 22 selects prescaler 4/5 or 8/9
// R15 - host keeps integer at least 23 or 75 per prescaler
// R16 - reference bit 21 inserts the divide-by-two halver
// R17 - reference bit 20 enables the doubler, both edges active
// R18 - buffered settings wait for a following divider write
// R19 - host writes fraction low before divider
// R20 - reference bits 19:15 divide reference by 1 to 32
// R21 - words are 32 bits, payload 31:3, code 2:0, held until rewritten
`timescale 1ns/1ps
`include "sdc_regs.svh"
module sdc_config_bank
  import sdc_pkg::*;
#(
  parameter int WORD_W = `SDC_WORD_W // serial word length in bits
) (
  input wire logic clk, // 200 mhz system clock
  input wire logic rst_n, // async reset, active low
  input wire logic ser_clk, // serial clock pin
  input wire logic ser_data, // serial data pin
  input wire logic ser_load, // load enable pin
  output sdc_cfg_t cfg, // active settings
  output sdc_sweep_t sweep, // sweep register images
  output logic reload_pulse // one-cycle pulse per divider write
);
  // ------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------
  // field positions below assume a 32-bit word
  if (WORD_W != 32) begin : g_bad_word
    $error("sdc_config_bank: word must be 32 bits");
  end
  // struct field widths must agree with the header layout
  if ($bits(cfg.output_mux_select) !=
      `SDC_DIV_MUX_HI - `SDC_DIV_MUX_LO + 1) begin : g_bad_mux
    $error("sdc_config_bank: mux select width mismatch");
  end
  if ($bits(cfg.int_value) !=
      `SDC_DIV_INT_HI - `SDC_DIV_INT_LO + 1) begin : g_bad_int
    $error("sdc_config_bank: integer width mismatch");
  end
  if ($bits(cfg.fractional_divide_value) !=
      `SDC_DIV_FMSB_HI - `SDC_DIV_FMSB_LO +
      `SDC_FRL_FLSB_HI - `SDC_FRL_FLSB_LO + 2) begin : g_bad_fractional_divide_value
    $error("sdc_config_bank: fraction width mismatch");
  end
  if ($bits(cfg.phase_word) !=
      `SDC_FRL_PH_HI - `SDC_FRL_PH_LO + 1) begin : g_bad_phase
    $error("sdc_config_bank: phase word width mismatch");
  end
  if ($bits(cfg.charge_pump_current) !=
      `SDC_REF_CP_HI - `SDC_REF_CP_LO + 1) begin : g_bad_pump
    $error("sdc_config_bank: pump current width mismatch");
  end
  if ($bits(cfg.reference_count) !=
      `SDC_REF_RCNT_HI - `SDC_REF_RCNT_LO + 1) begin : g_bad_rcount
    $error("sdc_config_bank: reference count width mismatch");
  end
  if ($bits(cfg.step_clock_divider) !=
      `SDC_REF_STEP_CLOCK_DIVIDER_HI - `SDC_REF_STEP_CLOCK_DIVIDER_LO + 1) begin : g_bad_step
    $error("sdc_config_bank: step divider width mismatch");
  end

  // ------------------------------------------------------------
  // serial capture
  // ------------------------------------------------------------
  // captured word and its one-cycle load strobe
  logic [WORD_W-1:0] word;
  logic word_valid;
  sdc_shift_in #(.WORD_W(WORD_W)) u_shift (
    .clk(clk),
    .rst_n(rst_n),
    .ser_clk(ser_clk),
    .ser_data(ser_data),
    .ser_load(ser_load),
    .word(word),
    .word_valid(word_valid)
  );

  // ------------------------------------------------------------
  // register images and buffered copies
  // ------------------------------------------------------------
  // live images, as last written by the host
  logic [31:0] div_r, div_nxt, frl_r, frl_nxt, ref_r, ref_nxt; // R21
  // copies in force, taken over on a divider write
  logic [31:0] frl_act_r, frl_act_nxt, ref_act_r, ref_act_nxt;
  logic rel_r, rel_nxt;

  // destination code match, used by every load path
  function automatic logic hit(input logic [31:0] w, input logic [2:0] a);
    hit = (w[2:0] == a);
  endfunction : hit

  // destination decode, codes 011 and 100 match nothing and drop
  always_comb begin
    div_nxt = div_r;
    frl_nxt = frl_r;
    ref_nxt = ref_r;
    if (word_valid) begin
      if (hit(word, `SDC_ADDR_DIV)) begin // R1
        div_nxt = word;
      end else if (hit(word, `SDC_ADDR_FRL)) begin // R1
        frl_nxt = word;
      end else if (hit(word, `SDC_ADDR_REF)) begin // R1
        ref_nxt = word;
      end
    end
  end

  // live image registers, held until rewritten
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= `SDC_RESET_WORD;
      frl_r <= `SDC_RESET_WORD;
      ref_r <= `SDC_RESET_WORD;
    end else begin
      div_r <= div_nxt;
      frl_r <= frl_nxt;
      ref_r <= ref_nxt;
    end
  end

  // ------------------------------------------------------------
  // buffered copies and reload strobe
  // ------------------------------------------------------------
  // a divider write takes over the pending fraction-low and reference
  always_comb begin
    frl_act_nxt = frl_act_r;
    ref_act_nxt = ref_act_r;
    rel_nxt = 1'b0;
    if (word_valid && hit(word, `SDC_ADDR_DIV)) begin // R18
      frl_act_nxt = frl_r; // R18
      ref_act_nxt = ref_r; // R18
      rel_nxt = 1'b1; // R7
    end
  end

  // buffered copy registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frl_act_r <= `SDC_RESET_WORD;
      ref_act_r <= `SDC_RESET_WORD;
      rel_r <= 1'b0;
    end else begin
      frl_act_r <= frl_act_nxt;
      ref_act_r <= ref_act_nxt;
      rel_r <= rel_nxt;
    end
  end

  // ------------------------------------------------------------
  // sweep images, stored raw for the ramp logic
  // ------------------------------------------------------------
  localparam int SWEEP_N = 3; // deviation, step, delay
  localparam logic [2:0] SWEEP_CODE [SWEEP_N] = '{`SDC_ADDR_DEV,
    `SDC_ADDR_STEP, `SDC_ADDR_DLY};
  logic [31:0] swp_r [SWEEP_N];
  logic [31:0] swp_nxt [SWEEP_N];

  // the sweep port carries exactly one word per image
  if ($bits(sweep) != SWEEP_N * 32) begin : g_bad_sweep
    $error("sdc_config_bank: sweep port width mismatch");
  end

  // one identical load path per sweep image
  for (genvar g = 0; g < SWEEP_N; g++) begin : g_sweep
    // load this image when its own code arrives
    always_comb begin
      swp_nxt[g] = swp_r[g];
      if (word_valid && hit(word, SWEEP_CODE[g])) begin // R21
        swp_nxt[g] = word;
      end
    end
    // image register, held until rewritten
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        swp_r[g] <= `SDC_RESET_WORD;
      end else begin
        swp_r[g] <= swp_nxt[g];
      end
    end
  end

  // ------------------------------------------------------------
  // field extraction onto the settings struct
  // ------------------------------------------------------------
  // settings struct wired straight from the images
  always_comb begin
    // divider fields act as soon as written
    cfg.ramp_enable = div_r[`SDC_DIV_RAMP_BIT]; // R2
    cfg.output_mux_select = div_r[`SDC_DIV_MUX_HI:`SDC_DIV_MUX_LO]; // R3
    cfg.int_value = div_r[`SDC_DIV_INT_HI:`SDC_DIV_INT_LO]; // R4
    // upper fraction live, lower fraction from the buffered copy
    cfg.fractional_divide_value = {div_r[`SDC_DIV_FMSB_HI:`SDC_DIV_FMSB_LO],
      frl_act_r[`SDC_FRL_FLSB_HI:`SDC_FRL_FLSB_LO]}; // R5
    // phase enable is live, the phase word waits for a divider write
    cfg.phase_enable = frl_r[`SDC_FRL_PHEN_BIT]; // R6
    cfg.phase_word = frl_act_r[`SDC_FRL_PH_HI:`SDC_FRL_PH_LO]; // R7
    cfg.phase_strobe = rel_r & frl_r[`SDC_FRL_PHEN_BIT]; // R6
    // slip reduction and prescaler live, reference path buffered
    cfg.cycle_slip_reduce_enable = ref_r[`SDC_REF_CSR_BIT]; // R10
    cfg.charge_pump_current = ref_act_r[`SDC_REF_CP_HI:`SDC_REF_CP_LO]; // R12
    cfg.prescaler = sdc_prescale_t'(ref_r[`SDC_REF_PRE_BIT]); // R14
    cfg.reference_halver_enable = ref_act_r[`SDC_REF_HALF_BIT]; // R16
    cfg.reference_doubler_enable = ref_act_r[`SDC_REF_DBL_BIT]; // R17
    cfg.reference_count = ref_act_r[`SDC_REF_RCNT_HI:`SDC_REF_RCNT_LO]; // R20
    cfg.step_clock_divider =
      ref_act_r[`SDC_REF_STEP_CLOCK_DIVIDER_HI:`SDC_REF_STEP_CLOCK_DIVIDER_LO]; // R18
  end

  // sweep images and reload strobe to the ports
  assign sweep = '{deviation: swp_r[0], step: swp_r[1], delay: swp_r[2]};
  assign reload_pulse = rel_r;
endmodule : sdc_config_bank

/* File: test/sdc_config_bank_assertions.sv */
// port assertions of the divider config bank
`timescale 1ns/1ps
module sdc_config_bank_assertions
  import sdc_pkg::*;
(
  input wire logic clk, // clock
  input wire logic rst_n, // reset, active low
  input wire logic ser_clk, // serial clock
  input wire logic ser_data, // serial data
  input wire logic ser_load, // load pin
  input sdc_cfg_t cfg, // settings
  input sdc_sweep_t sweep, // sweep images
  input wire logic reload_pulse // reload
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // reload lasts one cycle, the strobe is reload gated by phase enable in the same cycle, and the watched outputs move only after a load or a reload
  pulse_one_a: assert property (reload_pulse |=> !reload_pulse)
    else $error("reload pulse too long");
  strobe_tie_a: assert property (cfg.phase_strobe ==
    (reload_pulse && cfg.phase_enable)) else $error("bad phase strobe");
  reload_src_a: assert property (reload_pulse |->
    $past(ser_load, 3) || $past(ser_load, 6)) else $error("stray reload");
  int_src_a: assert property ($changed(cfg.int_value) |->
    $past(ser_load, 3) || $past(ser_load, 6)) else $error("stray int");
  sweep_src_a: assert property ($changed(sweep) |->
    $past(ser_load, 3) || $past(ser_load, 6)) else $error("stray sweep");
  pump_buf_a: assert property ($changed(cfg.charge_pump_current) |->
    reload_pulse || $past(reload_pulse)) else $error("pump not held");
  rcount_buf_a: assert property ($changed(cfg.reference_count) |->
    reload_pulse || $past(reload_pulse)) else $error("count not held");
  fractional_divide_value_buf_a: assert property ($changed(cfg.fractional_divide_value[12:0])
    |-> reload_pulse || $past(reload_pulse)) else $error("fractional_divide_value not held");
  phase_buf_a: assert property ($changed(cfg.phase_word) |->
    reload_pulse) else $error("phase word not held");
endmodule : sdc_config_bank_assertions
bind sdc_config_bank sdc_config_bank_assertions sdc_assert_inst (
  .clk(clk), .rst_n(rst_n), .ser_clk(ser_clk), .ser_data(ser_data),
  .ser_load(ser_load), .cfg(cfg), .sweep(sweep),
  .reload_pulse(reload_pulse));

/* File: test/sdc_host_model.sv */
// host side three-wire writer
`timescale 1ns/1ps
module sdc_host_model (
  input wire logic clk, // system clock
  output logic ser_clk, // serial clock
  output logic ser_data, // serial data
  output logic ser_load // load pin
);
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    ser_load = 1'b0;
  end
  // one word msb first, each clock level held three cycles, data six, load six
  task automatic send(input logic [31:0] w);
    for (int i = 31; i >= 0; i--) begin
      ser_clk <= 1'b0;
      ser_data <= w[i];
      repeat (3) @(negedge clk);
      ser_clk <= 1'b1;
      repeat (3) @(negedge clk);
    end
    ser_clk <= 1'b0;
    ser_data <= ~ser_data; // no stale bit between frames
    repeat (3) @(negedge clk);
    ser_load <= 1'b1;
    repeat (6) @(negedge clk);
    ser_load <= 1'b0;
    repeat (3) @(negedge clk);
  endtask : send
endmodule : sdc_host_model

/* File: test/sdc_config_bank_tb_top.sv */
// self-checking bench of the divider config bank
`timescale 1ns/1ps
`include "sdc_regs.svh"
module sdc_config_bank_tb_top;
  import sdc_pkg::*;
  typedef struct packed {logic [31:0] w; logic [7:0] rl;} sdc_row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  wire logic ser_clk, ser_data, ser_load;
  sdc_cfg_t cfg, e;
  sdc_sweep_t sweep, es;
  logic reload_pulse;
  logic [31:0] pf = '0;
  logic [31:0] pr = '0;
  int miscompares = 0;
  int n_compared = 0;
  int n_reload = 0;
  int n_strobe = 0;
  // words and the running count of reloads they should give
  sdc_row_t rows [12] = '{'{32'h1D5E1001, 8'h00}, '{32'h057FD5E2, 8'h00},
    '{32'hF8320918, 8'h01}, '{32'hFFFFFFFB, 8'h01}, '{32'hFFFFFFFC, 8'h01},
    '{32'h12345675, 8'h01}, '{32'h00ABCDE6, 8'h01}, '{32'h00012347, 8'h01},
    '{32'h1000000A, 8'h01}, '{32'h000B8000, 8'h02}, '{32'h00000001, 8'h02},
    '{32'h000B8008, 8'h03}};
  always #2.5 clk = ~clk;
  always @(posedge clk) if (reload_pulse === 1'b1) n_reload++;
  always @(posedge clk) if (cfg.phase_strobe === 1'b1) n_strobe++;
  sdc_config_bank sdc_config_bank_inst (.clk(clk), .rst_n(rst_n),
    .ser_clk(ser_clk), .ser_data(ser_data), .ser_load(ser_load),
    .cfg(cfg), .sweep(sweep), .reload_pulse(reload_pulse));
  sdc_host_model sdc_host_model_inst (.clk(clk), .ser_clk(ser_clk),
    .ser_data(ser_data), .ser_load(ser_load));
  // expected settings after one word
  task automatic expect_word(input logic [31:0] w);
    case (w[2:0])
      `SDC_ADDR_DIV: begin
        e.ramp_enable = w[31];
        e.output_mux_select = w[30:27];
        e.int_value = w[26:15];
        e.fractional_divide_value = {w[14:3], pf[27:15]};
        e.phase_word = pf[14:3];
        e.charge_pump_current = pr[27:24];
        e.reference_halver_enable = pr[21];
        e.reference_doubler_enable = pr[20];
        e.reference_count = pr[19:15];
        e.step_clock_divider = pr[14:3];
      end
      `SDC_ADDR_FRL: begin
        pf = w;
        e.phase_enable = w[28];
      end
      `SDC_ADDR_REF: begin
        pr = w;
        e.cycle_slip_reduce_enable = w[28];
        e.prescaler = sdc_prescale_t'(w[22]);
      end
      `SDC_ADDR_DEV: es.deviation = w;
      `SDC_ADDR_STEP: es.step = w;
      `SDC_ADDR_DLY: es.delay = w;
      default: ; // codes 011 and 100 change nothing
    endcase
  endtask : expect_word
  task automatic compare(input logic [95:0] got, input logic [95:0] want);
    n_compared++;
    if (got !== want) begin
      miscompares++;
      $display("[ERR] %0t got %h want %h", $time, got, want);
    end
  endtask : compare
  task automatic close_out;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out
  // watchdog on the whole run
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    close_out;
  end
  // rows, then a reset in mid-run
  initial begin
    e = '0;
    es = '0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    compare(96'(cfg), 96'(e));
    foreach (rows[i]) begin
      sdc_host_model_inst.send(rows[i].w);
      expect_word(rows[i].w);
      compare(96'(cfg), 96'(e));
      compare(96'(sweep), 96'(es));
      compare(96'(n_reload), 96'(rows[i].rl));
    end
    compare(96'(n_strobe), 96'(2));
    rst_n = 1'b0;
    repeat (4) @(negedge clk);
    compare(96'(cfg), 96'(0));
    compare(96'(sweep), 96'(0));
    rst_n = 1'b1;
    e = '0;
    pf = '0;
    pr = '0;
    sdc_host_model_inst.send(32'hF8320918);
    expect_word(32'hF8320918);
    compare(96'(cfg), 96'(e));
    close_out;
  end
endmodule : sdc_config_bank_tb_top
